// ===== btq_pkg.sv
package btq_pkg;
  // register map, byte addresses of 32-bit words
  localparam logic [7:0] BTQ_CTRL_OFS = 8'h00;
  localparam logic [7:0] BTQ_TSTAT_OFS = 8'h04;
  localparam logic [7:0] BTQ_TFLAG_OFS = 8'h08;
  localparam logic [7:0] BTQ_TMASK_OFS = 8'h0C;
  localparam logic [7:0] BTQ_ISTAT_OFS = 8'h10;
  localparam logic [7:0] BTQ_IMASK_OFS = 8'h14;

  // timing
  localparam int BTQ_CLK_PERIOD_NS = 20;
  localparam int BTQ_INT_PULSE_US = 256;
  localparam int BTQ_INT_PULSE_CYC = (BTQ_INT_PULSE_US * 1000)
                                     / BTQ_CLK_PERIOD_NS;

  // comparator vector bit positions
  localparam int BTQ_CMP_COLD = 0;
  localparam int BTQ_CMP_COOL = 1;
  localparam int BTQ_CMP_WARM = 2;
  localparam int BTQ_CMP_HOT = 3;
  localparam int BTQ_CMP_RCOLD = 4;
  localparam int BTQ_CMP_RHOT = 5;
  localparam int BTQ_NCMP = 6;

  // interrupt status bits
  localparam int BTQ_IRQ_REGION = 0;
  localparam int BTQ_IRQ_TERM = 1;
  localparam int BTQ_IRQ_OVP = 2;
  localparam int BTQ_IRQ_RSUSP = 3;
  localparam int BTQ_NIRQ = 4;

  // reset values
  localparam logic [15:0] BTQ_CTRL_RST = 16'h0000;
  localparam logic [3:0] BTQ_TMASK_RST = 4'h0;
  localparam logic [3:0] BTQ_IMASK_RST = 4'h0;

  typedef enum logic [2:0] {
    BTQ_REG_NORMAL = 3'b000,
    BTQ_REG_COLD = 3'b001,
    BTQ_REG_COOL = 3'b010,
    BTQ_REG_WARM = 3'b011,
    BTQ_REG_HOT = 3'b100
  } btq_region_t;

  typedef enum logic [1:0] {
    BTQ_CUR_20 = 2'b00,
    BTQ_CUR_40 = 2'b01,
    BTQ_CUR_100 = 2'b10,
    BTQ_CUR_SUSP = 2'b11
  } btq_cur_t;

  typedef enum logic [1:0] {
    BTQ_VOFS_0 = 2'b00,
    BTQ_VOFS_100 = 2'b01,
    BTQ_VOFS_200 = 2'b10,
    BTQ_VOFS_SUSP = 2'b11
  } btq_vofs_t;

  typedef enum logic [1:0] {
    BTQ_TMR_PAUSE = 2'b00,
    BTQ_TMR_HALF = 2'b01,
    BTQ_TMR_FULL = 2'b10
  } btq_tmr_t;

  // control register layout, bits [15:0]
  typedef struct packed {
    logic [1:0] spare;
    logic reverse_output_enable;
    logic term_enable;
    logic temp_interrupt_mask;
    logic thermistor_ignore;
    logic [1:0] warm_threshold_select;
    logic [1:0] cool_threshold_select;
    btq_cur_t warm_current_scale;
    btq_vofs_t warm_voltage_offset;
    btq_cur_t cool_current_scale;
  } btq_ctrl_t;

  // charge policy handed to the charger core
  typedef struct packed {
    logic charge_allowed;
    btq_cur_t current_scale;
    btq_vofs_t voltage_offset;
    logic term_active;
    btq_tmr_t timer_rate;
  } btq_policy_t;
endpackage

// ===== btq_qualifier.sv
// Operation
// [R1] charging may start or continue only between the cold and hot limits.
// [R2] the cool region scales current to 20, 40 or 100 percent or suspends.
// [R3] the warm region lowers voltage by 0, 100 or 200 mV or suspends.
// [R4] the warm region scales current to 20, 40 or 100 percent or suspends.
// [R5] termination stays on in cool and warm with one common threshold.
// [R6] low scaled current terminates when above recharge and in the cv loop.
// [R7] an overvoltage after the warm voltage drop gets the usual handling.
// [R8] the safety timer pauses on suspend and runs half rate at 20 or 40.
// [R9] ignoring the thermistor means always good and status bits all zero.
// [R10] a region change updates status, sets its flag and pulses interrupt.
// [R11] each region flag and its interrupt can be masked individually.
// [R12] cold and hot thresholds are fixed, cool and warm are selectable.
// [R13] outside the reverse window switching stops with enable kept set.
// [R14] back inside the reverse window output resumes and status clears.
// [R15] each host interrupt is a low pulse of about 256 microseconds.
// [R16] flags clear on read and need a new status rising edge to reset.
// [R17] exactly one region is derived and each crossing is reported once.
module btq_qualifier
  import btq_pkg::*;
#(
  parameter int INT_PULSE_CYCLES = BTQ_INT_PULSE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // comparators, high when the sense voltage is past that limit
  input wire logic [BTQ_NCMP-1:0] cmp_in,
  output logic [1:0] cool_threshold_select,
  output logic [1:0] warm_threshold_select,
  // charger core conditions
  input wire logic curr_below_term,
  input wire logic vbat_above_recharge,
  input wire logic cv_loop_active,
  input wire logic battery_overvoltage,
  // charge policy
  output btq_policy_t policy,
  output logic terminate,
  output logic ovp_protect,
  // reverse output
  output logic reverse_output_enable,
  output logic reverse_switch_en,
  output logic input_source_zero,
  // host interrupts
  output logic host_int_b,
  output logic irq
);

  localparam int NSYNC = BTQ_NCMP + 4;

  // three-stage synchronisers; stage 1 feeds stage 2 only
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_r, s2_r, s3_r, filt_r;
  logic [NSYNC-1:0] s1_nxt, s2_nxt, s3_nxt, filt_nxt;

  assign raw = {battery_overvoltage, cv_loop_active, vbat_above_recharge,
                curr_below_term, cmp_in};

  // a bit moves only once stages 2 and 3 agree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_flt
      always_comb begin
        if (s2_r[gi] == s3_r[gi]) begin
          filt_nxt[gi] = s3_r[gi];
        end else begin
          filt_nxt[gi] = filt_r[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    s1_nxt = raw;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      filt_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      filt_r <= filt_nxt;
    end
  end

  // filtered view; nothing below reads the raw pins
  logic [BTQ_NCMP-1:0] cmp;
  logic below_term, above_rchg, cv_loop, ovp_in;
  assign cmp = filt_r[BTQ_NCMP-1:0];
  assign below_term = filt_r[BTQ_NCMP];
  assign above_rchg = filt_r[BTQ_NCMP+1];
  assign cv_loop = filt_r[BTQ_NCMP+2];
  assign ovp_in = filt_r[BTQ_NCMP+3];

  // registers
  btq_ctrl_t ctrl_r, ctrl_nxt;
  logic [3:0] tflag_r, tflag_nxt, tmask_r, tmask_nxt;
  logic [BTQ_NIRQ-1:0] istat_r, istat_nxt, imask_r, imask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  btq_region_t region_r, region_nxt, region_raw;
  logic [3:0] tstat_r, tstat_nxt;
  logic term_r, term_nxt;
  logic rsusp_r, rsusp_nxt;
  logic ovp_r, ovp_nxt;
  logic rsw_r, rsw_nxt;
  logic [15:0] pulse_cnt_r, pulse_cnt_nxt;

  logic wr_ctrl, wr_tmask, wr_istat, wr_imask, rd_tflag;
  assign wr_ctrl = reg_wr && reg_addr == BTQ_CTRL_OFS;
  assign wr_tmask = reg_wr && reg_addr == BTQ_TMASK_OFS;
  assign wr_istat = reg_wr && reg_addr == BTQ_ISTAT_OFS;
  assign wr_imask = reg_wr && reg_addr == BTQ_IMASK_OFS;
  assign rd_tflag = reg_rd && reg_addr == BTQ_TFLAG_OFS;

  // cold and hot win over cool and warm so one region holds at a time
  always_comb begin
    if (cmp[BTQ_CMP_COLD]) begin
      region_raw = BTQ_REG_COLD; // [R17]
    end else if (cmp[BTQ_CMP_HOT]) begin
      region_raw = BTQ_REG_HOT;
    end else if (cmp[BTQ_CMP_COOL]) begin
      region_raw = BTQ_REG_COOL;
    end else if (cmp[BTQ_CMP_WARM]) begin
      region_raw = BTQ_REG_WARM;
    end else begin
      region_raw = BTQ_REG_NORMAL;
    end
  end

  // reverse window uses its own comparators
  logic rev_out_window, rev_run;
  // ignoring the thermistor also keeps reverse output running
  assign rev_out_window = !ctrl_r.thermistor_ignore &&
                          (cmp[BTQ_CMP_RCOLD] || cmp[BTQ_CMP_RHOT]);
  assign rev_run = ctrl_r.reverse_output_enable && !rev_out_window;

  // status bits and charge policy
  btq_policy_t pol;
  btq_cur_t cur;
  always_comb begin
    if (ctrl_r.thermistor_ignore) begin
      region_nxt = BTQ_REG_NORMAL; // [R9]
    end else begin
      region_nxt = region_raw;
    end
    // one status bit at most, same layout as the flags
    tstat_nxt = '0;
    if (ctrl_r.reverse_output_enable) begin
      // only the reverse window faults are reported
      tstat_nxt[0] = rev_out_window && cmp[BTQ_CMP_RCOLD]; // [R13] [R14]
      tstat_nxt[3] = rev_out_window && !cmp[BTQ_CMP_RCOLD];
    end else begin
      case (region_nxt)
        BTQ_REG_COLD: tstat_nxt[0] = 1'b1; // [R10]
        BTQ_REG_COOL: tstat_nxt[1] = 1'b1;
        BTQ_REG_WARM: tstat_nxt[2] = 1'b1;
        BTQ_REG_HOT: tstat_nxt[3] = 1'b1;
        default: tstat_nxt = '0;
      endcase
    end

    pol.voltage_offset = BTQ_VOFS_0;
    case (region_r)
      BTQ_REG_COOL: cur = ctrl_r.cool_current_scale; // [R2]
      BTQ_REG_WARM: begin
        cur = ctrl_r.warm_current_scale; // [R4]
        pol.voltage_offset = ctrl_r.warm_voltage_offset; // [R3]
      end
      BTQ_REG_NORMAL: cur = BTQ_CUR_100;
      default: cur = BTQ_CUR_SUSP; // [R1]
    endcase
    pol.current_scale = cur;
    pol.charge_allowed = cur != BTQ_CUR_SUSP &&
                         pol.voltage_offset != BTQ_VOFS_SUSP; // [R1]
    // same threshold in every region, gated by the enable and by charge_allowed
    pol.term_active = ctrl_r.term_enable && pol.charge_allowed; // [R5]
    if (!pol.charge_allowed) begin
      pol.timer_rate = BTQ_TMR_PAUSE; // [R8]
    end else if (cur == BTQ_CUR_20 || cur == BTQ_CUR_40) begin
      pol.timer_rate = BTQ_TMR_HALF;
    end else begin
      pol.timer_rate = BTQ_TMR_FULL;
    end
    term_nxt = pol.term_active && below_term && above_rchg && cv_loop; // [R6]
    rsusp_nxt = ctrl_r.reverse_output_enable && !rev_run;
    rsw_nxt = rev_run; // [R14]
    ovp_nxt = ovp_in;
  end

  // events, flags and interrupt status; a set beats a clear
  logic [3:0] trise;
  logic [BTQ_NIRQ-1:0] ev;
  logic int_fire;
  always_comb begin
    trise = tstat_nxt & ~tstat_r; // [R17]
    ev = '0;
    ev[BTQ_IRQ_REGION] = |(trise & ~tmask_r);
    ev[BTQ_IRQ_TERM] = term_nxt && !term_r;
    ev[BTQ_IRQ_OVP] = ovp_nxt && !ovp_r; // [R7]
    ev[BTQ_IRQ_RSUSP] = rsusp_nxt && !rsusp_r;
    // the flag still records a crossing whose pulse is masked globally
    tflag_nxt = rd_tflag ? 4'h0 : tflag_r; // [R16]
    tflag_nxt = tflag_nxt | (trise & ~tmask_r); // [R11]
    istat_nxt = wr_istat ? (istat_r & ~reg_wdata[BTQ_NIRQ-1:0]) : istat_r;
    istat_nxt = istat_nxt | ev;
    int_fire = (ev[BTQ_IRQ_REGION] && !ctrl_r.temp_interrupt_mask) || // [R10]
               ev[BTQ_IRQ_TERM] || ev[BTQ_IRQ_OVP] || ev[BTQ_IRQ_RSUSP];
    // a new event restarts the pulse rather than being dropped
    if (int_fire) begin
      pulse_cnt_nxt = 16'(INT_PULSE_CYCLES); // [R15]
    end else if (pulse_cnt_r != 16'h0000) begin
      pulse_cnt_nxt = pulse_cnt_r - 16'h0001;
    end else begin
      pulse_cnt_nxt = pulse_cnt_r;
    end
    ctrl_nxt = wr_ctrl ? btq_ctrl_t'(reg_wdata[15:0]) : ctrl_r;
    tmask_nxt = wr_tmask ? reg_wdata[3:0] : tmask_r;
    imask_nxt = wr_imask ? reg_wdata[BTQ_NIRQ-1:0] : imask_r;
  end

  // read data, valid the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        BTQ_CTRL_OFS: rdata_nxt[15:0] = ctrl_r;
        BTQ_TSTAT_OFS: begin
          rdata_nxt[3:0] = tstat_r;
          rdata_nxt[6:4] = region_r;
          rdata_nxt[7] = policy.charge_allowed;
          rdata_nxt[8] = rsusp_r;
        end
        BTQ_TFLAG_OFS: rdata_nxt[3:0] = tflag_r;
        BTQ_TMASK_OFS: rdata_nxt[3:0] = tmask_r;
        BTQ_ISTAT_OFS: rdata_nxt[BTQ_NIRQ-1:0] = istat_r;
        BTQ_IMASK_OFS: rdata_nxt[BTQ_NIRQ-1:0] = imask_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r <= btq_ctrl_t'(BTQ_CTRL_RST);
      tmask_r <= BTQ_TMASK_RST;
      imask_r <= BTQ_IMASK_RST;
      tflag_r <= 4'h0;
      istat_r <= 4'h0;
      tstat_r <= 4'h0;
      region_r <= BTQ_REG_NORMAL;
      term_r <= 1'b0;
      rsusp_r <= 1'b0;
      ovp_r <= 1'b0;
      rsw_r <= 1'b0;
      pulse_cnt_r <= 16'h0000;
      rdata_r <= 32'h0000_0000;
      policy <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      tmask_r <= tmask_nxt;
      imask_r <= imask_nxt;
      tflag_r <= tflag_nxt;
      istat_r <= istat_nxt;
      tstat_r <= tstat_nxt;
      region_r <= region_nxt;
      term_r <= term_nxt;
      rsusp_r <= rsusp_nxt;
      ovp_r <= ovp_nxt;
      rsw_r <= rsw_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
      rdata_r <= rdata_nxt;
      policy <= pol;
    end
  end

  // outputs
  assign reg_rdata = rdata_r;
  assign terminate = term_r; // [R6]
  assign ovp_protect = ovp_r; // [R7]
  assign cool_threshold_select = ctrl_r.cool_threshold_select; // [R12]
  assign warm_threshold_select = ctrl_r.warm_threshold_select; // [R12]
  // enable stays set while switching is held off
  assign reverse_output_enable = ctrl_r.reverse_output_enable; // [R13]
  // registered, so enabling inside a fault never lets one cycle switch
  assign reverse_switch_en = ctrl_r.reverse_output_enable && rsw_r; // [R14]
  assign input_source_zero = rsusp_r; // [R13]
  assign host_int_b = pulse_cnt_r == 16'h0000; // [R15]
  assign irq = |(istat_r & imask_r);

endmodule

// ===== btq_therm_model.sv
module btq_therm_model
  import btq_pkg::*;
(
  // sense level, 0 below reverse cold up to 5 hot
  input wire logic [2:0] temp,
  // comparator levels
  output logic [BTQ_NCMP-1:0] cmp_in
);
  // nested limits, so a cold level also raises cool and a hot level also raises warm
  always_comb begin
    cmp_in = '0;
    cmp_in[BTQ_CMP_RCOLD] = temp == 3'h0;
    cmp_in[BTQ_CMP_COLD] = temp <= 3'h1;
    cmp_in[BTQ_CMP_COOL] = temp <= 3'h2;
    cmp_in[BTQ_CMP_WARM] = temp >= 3'h4;
    cmp_in[BTQ_CMP_HOT] = temp >= 3'h5;
    cmp_in[BTQ_CMP_RHOT] = temp >= 3'h5;
  end
endmodule

// ===== btq_qualifier_chk.sv
module btq_qualifier_chk
  import btq_pkg::*;
#(
  parameter int INT_PULSE_CYCLES = BTQ_INT_PULSE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // charger conditions
  input wire logic curr_below_term,
  input wire logic vbat_above_recharge,
  input wire logic cv_loop_active,
  input wire logic battery_overvoltage,
  // watched outputs
  input wire btq_policy_t policy,
  input wire logic terminate,
  input wire logic ovp_protect,
  input wire logic reverse_output_enable,
  input wire logic reverse_switch_en,
  input wire logic input_source_zero,
  input wire logic host_int_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] low_cnt_r;
  logic [15:0] low_cnt_nxt;
  logic term_cond;
  assign term_cond = curr_below_term && vbat_above_recharge &&
                     cv_loop_active && policy.term_active;
  // restarts only lengthen a pulse, so the floor is the safe bound
  always_comb begin
    low_cnt_nxt = host_int_b ? 16'h0000 : low_cnt_r + 16'h0001;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      low_cnt_r <= 16'h0000;
    end else begin
      low_cnt_r <= low_cnt_nxt;
    end
  end
  susp_no_charge_a: assert property (
    policy.current_scale == BTQ_CUR_SUSP |-> !policy.charge_allowed)
    else $error("charge allowed with suspended current");
  timer_pause_a: assert property (
    !policy.charge_allowed |-> policy.timer_rate == BTQ_TMR_PAUSE)
    else $error("timer runs while suspended");
  timer_rate_a: assert property (
    policy.charge_allowed |-> policy.timer_rate ==
    (policy.current_scale == BTQ_CUR_100 ? BTQ_TMR_FULL : BTQ_TMR_HALF))
    else $error("timer rate does not follow scale");
  term_gate_a: assert property (
    policy.term_active |-> policy.charge_allowed)
    else $error("termination active without charge");
  term_meet_a: assert property (
    term_cond [*8] |-> terminate)
    else $error("termination condition ignored");
  term_cv_a: assert property (
    !cv_loop_active [*8] |-> !terminate)
    else $error("terminated outside voltage loop");
  ovp_follow_a: assert property (
    battery_overvoltage [*8] |-> ovp_protect)
    else $error("overvoltage not handled");
  pulse_len_a: assert property (
    $rose(host_int_b) |-> low_cnt_r >= INT_PULSE_CYCLES)
    else $error("interrupt pulse too short");
  rev_switch_a: assert property (
    reverse_switch_en |-> reverse_output_enable && !input_source_zero)
    else $error("reverse switching while suspended");
  cover property ($fell(host_int_b));
  cover property ($rose(terminate));
  cover property (reverse_output_enable && !reverse_switch_en);
endmodule

bind btq_qualifier btq_qualifier_chk #(
  .INT_PULSE_CYCLES(INT_PULSE_CYCLES)
) btq_qualifier_chk_inst (
  .clk(clk), .rst_b(rst_b), .curr_below_term(curr_below_term),
  .vbat_above_recharge(vbat_above_recharge),
  .cv_loop_active(cv_loop_active),
  .battery_overvoltage(battery_overvoltage), .policy(policy),
  .terminate(terminate), .ovp_protect(ovp_protect),
  .reverse_output_enable(reverse_output_enable),
  .reverse_switch_en(reverse_switch_en),
  .input_source_zero(input_source_zero), .host_int_b(host_int_b)
);

// ===== btq_qualifier_tb_top.sv
module btq_qualifier_tb_top
  import btq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic curr_below_term = 1'b0;
  logic vbat_above_recharge = 1'b0;
  logic cv_loop_active = 1'b0;
  logic battery_overvoltage = 1'b0;
  logic [2:0] temp = 3'h3;
  logic [31:0] reg_rdata, v;
  wire logic [BTQ_NCMP-1:0] cmp_in;
  btq_policy_t policy;
  logic terminate, ovp_protect, reverse_output_enable, reverse_switch_en;
  logic input_source_zero, host_int_b, irq, int_q = 1'b1;
  logic [1:0] s, cool_sel, warm_sel;
  int failures = 0, n_compared = 0, cyc = 0, n_pulse = 0, n0;

  always #10 clk = ~clk;

  btq_therm_model btq_therm_model_inst (.temp(temp), .cmp_in(cmp_in));
  btq_qualifier #(.INT_PULSE_CYCLES(8)) btq_qualifier_inst (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_in(cmp_in), .cool_threshold_select(cool_sel),
    .warm_threshold_select(warm_sel),
    .curr_below_term(curr_below_term),
    .vbat_above_recharge(vbat_above_recharge),
    .cv_loop_active(cv_loop_active),
    .battery_overvoltage(battery_overvoltage), .policy(policy),
    .terminate(terminate), .ovp_protect(ovp_protect),
    .reverse_output_enable(reverse_output_enable),
    .reverse_switch_en(reverse_switch_en),
    .input_source_zero(input_source_zero), .host_int_b(host_int_b),
    .irq(irq));

  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic go(input logic [2:0] t);
    @(posedge clk);
    temp <= t;
    nap(10);
  endtask
  task automatic cond(input logic [3:0] c);
    @(posedge clk);
    {curr_below_term, vbat_above_recharge} <= c[3:2];
    {cv_loop_active, battery_overvoltage} <= c[1:0];
    nap(10);
  endtask
  function automatic btq_tmr_t tmr(input logic [1:0] x);
    return x == 2'b11 ? BTQ_TMR_PAUSE :
           (x == 2'b10 ? BTQ_TMR_FULL : BTQ_TMR_HALF);
  endfunction

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (int_q && !host_int_b) n_pulse++;
    int_q <= host_int_b;
    if (cyc == 5000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    nap(6);
    rd(BTQ_TSTAT_OFS, v);
    chk(v, 32'h0000_0080);
    rd(8'h20, v);
    chk(v, 32'h0000_0000);
    wr(BTQ_IMASK_OFS, 32'h0000_0001);
    go(3'h2);
    rd(BTQ_TSTAT_OFS, v);
    chk(v, 32'h0000_00A2);
    chk(n_pulse, 1);
    chk(irq, 1'b1);
    rd(BTQ_TFLAG_OFS, v);
    chk(v, 32'h0000_0002);
    rd(BTQ_TFLAG_OFS, v);
    chk(v, 32'h0000_0000);
    wr(BTQ_ISTAT_OFS, 32'h0000_0001);
    nap(2);
    chk(irq, 1'b0);
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      wr(BTQ_CTRL_OFS, {30'h0000_0000, s});
      nap(4);
      chk(policy, {s != 2'b11, s, 2'b00, 1'b0, tmr(s)});
    end
    go(3'h4);
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      wr(BTQ_CTRL_OFS, {26'h000_0000, s, s, 2'b00});
      nap(4);
      chk(policy, {s != 2'b11, s, s, 1'b0, tmr(s)});
    end
    wr(BTQ_TMASK_OFS, 32'h0000_0001);
    rd(BTQ_TFLAG_OFS, v);
    n0 = n_pulse;
    go(3'h1);
    rd(BTQ_TFLAG_OFS, v);
    chk(v, 32'h0000_0000);
    chk(n_pulse, n0);
    rd(BTQ_TSTAT_OFS, v);
    chk(v, 32'h0000_0011);
    go(3'h5);
    rd(BTQ_TSTAT_OFS, v);
    chk(v, 32'h0000_0048);
    chk(n_pulse, n0 + 1);
    wr(BTQ_CTRL_OFS, 32'h0000_0240);
    nap(1);
    chk({warm_sel, cool_sel}, 4'h9);
    wr(BTQ_CTRL_OFS, 32'h0000_0800);
    go(3'h4);
    chk(n_pulse, n0 + 1);
    rd(BTQ_TFLAG_OFS, v);
    chk(v, 32'h0000_000C);
    wr(BTQ_CTRL_OFS, 32'h0000_1000);
    go(3'h2);
    cond(4'b1110);
    chk({policy.term_active, terminate}, 2'b11);
    cond(4'b1100);
    chk(terminate, 1'b0);
    go(3'h4);
    cond(4'b0001);
    chk(ovp_protect, 1'b1);
    cond(4'b0000);
    wr(BTQ_CTRL_OFS, 32'h0000_0400);
    go(3'h5);
    rd(BTQ_TSTAT_OFS, v);
    chk(v[3:0], 4'h0);
    chk(policy.charge_allowed, 1'b1);
    wr(BTQ_CTRL_OFS, 32'h0000_2000);
    go(3'h0);
    chk({reverse_output_enable, reverse_switch_en}, 2'b10);
    chk(input_source_zero, 1'b1);
    rd(BTQ_TSTAT_OFS, v);
    chk(v[0], 1'b1);
    go(3'h3);
    chk({reverse_switch_en, input_source_zero}, 2'b10);
    rd(BTQ_TSTAT_OFS, v);
    chk(v[3:0], 4'h0);
    finish_test();
  end
endmodule
